// ---- src/sbg_top.v ----
// Burst pattern and PRBS generator for channel 0 dividers, with APB register slave
//
// Overview of operation
// R1 - Eight-bit gap length in divider cycles
// R2 - Mode bit clear: one burst per edge
// R3 - Mode bit set: bursts repeat while trigger high
// R4 - Six-bit field sets pulses per burst
// R5 - PRBS enable gives pseudorandom output
// R6 - Burst enable mutes output until requested
// R7 - Software uses burst only with ratio eight+
// R8 - Programmed gap inserted between periodic bursts
`include "sbg_defines.vh"

module sbg_top (
    input  wire                   MCLK_I,         // 250 MHz clock
    input  wire                   RESET_I,        // Async reset, active high
    input  wire                   PSEL_I,         // APB select
    input  wire                   PENABLE_I,      // APB access phase
    input  wire                   PWRITE_I,       // APB direction
    input  wire [17:0]            PADDR_I,        // APB byte address
    input  wire [31:0]            PWDATA_I,       // APB write data
    output wire                   PREADY_O,       // APB ready
    output reg  [31:0]            PRDATA_O,       // APB read data
    output wire                   PSLVERR_O,      // APB error (unmapped)
    input  wire                   TRIGGER_I,      // Burst trigger level
    input  wire [`SBG_NOUT-1:0]   DIV_TICK_I,     // Divider cycle pulse per output
    output wire [`SBG_NOUT-1:0]   DIVIDER_OUT_O,  // Gated outputs, a_pos..c_neg
    output wire [`SBG_NOUT-1:0]   BURST_BUSY_O,   // Burst or gap in progress
    output wire                   RETIME_EN_O,    // Retime enable bit
    output wire [7:0]             DRIVER_A_O,     // Driver A configuration
    output wire [7:0]             DRIVER_B_O,     // Driver B configuration
    output wire [7:0]             DRIVER_C_O,     // Driver C configuration
    output wire [7:0]             SEC_PATH_O,     // Secondary clock path
    output wire [7:0]             SYNC_CTRL_O,    // Sync control
    output wire [7:0]             MUTE_MASK_O     // Auto-unmute mask
);

    // Configuration registers
    reg [7:0] gap_len_r;     // Gap length
    reg [7:0] request_r;     // Mode bit and burst count
    reg [7:0] en_low_r;      // Enables for outputs A and B
    reg [7:0] en_high_r;     // Enables for output C
    reg [7:0] retime_r;      // Retime control
    reg [7:0] drv_a_r;       // Driver A
    reg [7:0] drv_b_r;       // Driver B
    reg [7:0] drv_c_r;       // Driver C
    reg [7:0] sec_path_r;    // Secondary path
    reg [7:0] sync_r;        // Sync control
    reg [7:0] mute_r;        // Auto-unmute mask

    reg                   trig_d_r;   // Trigger delayed for edge detect
    wire                  trig_rise;  // Trigger rising edge
    wire [15:0]           reg_idx;    // Word index from byte address
    wire                  acc;        // APB write access completes
    wire                  hit;        // Address is mapped
    wire [`SBG_NOUT-1:0]  burst_en;   // Per-output burst enables
    wire [`SBG_NOUT-1:0]  prbs_en;    // Per-output PRBS enables
    reg  [31:0]           rdata_nxt;  // Next read data

    // Index decode for the read mux; the error check uses a range compare
    function [7:0] sbg_rd;
        input [15:0] idx;
        input [7:0]  g, q, l, h, t, a, b, c, s, y, m, st;
        begin
            case (idx)
                `SBG_IDX_GAP:     sbg_rd = g;
                `SBG_IDX_REQ:     sbg_rd = q;
                `SBG_IDX_ENLO:    sbg_rd = l;
                `SBG_IDX_ENHI:    sbg_rd = h;
                `SBG_IDX_RETIME:  sbg_rd = t;
                `SBG_IDX_DRVA:    sbg_rd = a;
                `SBG_IDX_DRVB:    sbg_rd = b;
                `SBG_IDX_DRVC:    sbg_rd = c;
                `SBG_IDX_SECPATH: sbg_rd = s;
                `SBG_IDX_SYNC:    sbg_rd = y;
                `SBG_IDX_MUTE:    sbg_rd = m;
                `SBG_IDX_STATUS:  sbg_rd = st;
                default:          sbg_rd = `SBG_RST_ZERO;
            endcase
        end
    endfunction

    assign reg_idx   = PADDR_I[17:2];
    assign hit       = (reg_idx >= `SBG_IDX_GAP) && (reg_idx <= `SBG_IDX_STATUS);
    // Zero-wait slave: ready whenever accessed
    assign PREADY_O  = 1'b1;
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;
    assign acc       = PSEL_I & PENABLE_I & PWRITE_I & hit;

    // Register writes; reserved bits masked to read zero
    always @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            gap_len_r  <= `SBG_RST_ZERO;
            request_r  <= `SBG_RST_ZERO;
            en_low_r   <= `SBG_RST_ZERO;
            en_high_r  <= `SBG_RST_ZERO;
            retime_r   <= `SBG_RST_ZERO;
            drv_a_r    <= `SBG_RST_DRV;
            drv_b_r    <= `SBG_RST_DRV;
            drv_c_r    <= `SBG_RST_DRV;
            sec_path_r <= `SBG_RST_ZERO;
            sync_r     <= `SBG_RST_ZERO;
            mute_r     <= `SBG_RST_ZERO;
        end else if (acc) begin
            case (reg_idx)
                `SBG_IDX_GAP:     gap_len_r  <= PWDATA_I[7:0]; // R1
                `SBG_IDX_REQ:     request_r  <= PWDATA_I[7:0] & `SBG_REQ_MASK;
                `SBG_IDX_ENLO:    en_low_r   <= PWDATA_I[7:0];
                `SBG_IDX_ENHI:    en_high_r  <= PWDATA_I[7:0] & `SBG_ENHI_MASK;
                `SBG_IDX_RETIME:  retime_r   <= PWDATA_I[7:0] & `SBG_RETIME_MASK;
                `SBG_IDX_DRVA:    drv_a_r    <= PWDATA_I[7:0] & `SBG_DRV_MASK;
                `SBG_IDX_DRVB:    drv_b_r    <= PWDATA_I[7:0] & `SBG_DRV_MASK;
                `SBG_IDX_DRVC:    drv_c_r    <= PWDATA_I[7:0] & `SBG_DRV_MASK;
                `SBG_IDX_SECPATH: sec_path_r <= PWDATA_I[7:0] & `SBG_ENHI_MASK;
                `SBG_IDX_SYNC:    sync_r     <= PWDATA_I[7:0] & `SBG_SYNC_MASK;
                `SBG_IDX_MUTE:    mute_r     <= PWDATA_I[7:0];
                default:          sync_r     <= sync_r; // Status is read-only
            endcase
        end
    end

    // Read data registered during setup so it is valid in the access phase
    always @* begin
        rdata_nxt = {24'h00_0000, sbg_rd(reg_idx, gap_len_r, request_r, en_low_r,
            en_high_r, retime_r, drv_a_r, drv_b_r, drv_c_r, sec_path_r, sync_r,
            mute_r, {2'b00, BURST_BUSY_O})};
    end

    always @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            PRDATA_O <= 32'h0000_0000;
        end else if (PSEL_I && !PENABLE_I) begin
            PRDATA_O <= rdata_nxt;
        end
    end

    // Trigger edge detector; trigger is synchronous to the clock
    always @(posedge MCLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= TRIGGER_I;
        end
    end
    assign trig_rise = TRIGGER_I & ~trig_d_r; // R2

    // Enable bits: even bit burst, odd bit PRBS, per output a_pos..c_neg
    assign burst_en = {en_high_r[2], en_high_r[0], en_low_r[6], en_low_r[4],
                       en_low_r[2], en_low_r[0]}; // R6
    assign prbs_en  = {en_high_r[3], en_high_r[1], en_low_r[7], en_low_r[5],
                       en_low_r[3], en_low_r[1]}; // R5

    // One engine per divider output; divider ratio >= 8 is software's duty (R7)
    genvar gi;
    generate
        for (gi = 0; gi < `SBG_NOUT; gi = gi + 1) begin : g_lane
            sbg_output_lane u_lane (
                .clk_i       (MCLK_I),
                .rst_i       (RESET_I),
                .tick_i      (DIV_TICK_I[gi]),
                .burst_en_i  (burst_en[gi]),
                .prbs_en_i   (prbs_en[gi]),
                .periodic_i  (request_r[`SBG_REQ_MODE_BIT]), // R3
                .trig_i      (TRIGGER_I),
                .trig_rise_i (trig_rise),
                .count_i     (request_r[`SBG_REQ_CNT_HI:`SBG_REQ_CNT_LO]), // R4
                .gap_i       (gap_len_r), // R1
                .out_o       (DIVIDER_OUT_O[gi]),
                .busy_o      (BURST_BUSY_O[gi])
            );
        end
    endgenerate

    // Mapped-only configuration outputs
    assign RETIME_EN_O = retime_r[0];
    assign DRIVER_A_O  = drv_a_r;
    assign DRIVER_B_O  = drv_b_r;
    assign DRIVER_C_O  = drv_c_r;
    assign SEC_PATH_O  = sec_path_r;
    assign SYNC_CTRL_O = sync_r;
    assign MUTE_MASK_O = mute_r;

endmodule

// ---- src/sbg_defines.vh ----
// Register offsets, field positions, reset values and constants for the burst generator
`ifndef SBG_DEFINES_VH
`define SBG_DEFINES_VH

// Register indices, as printed; byte address is four times the index
`define SBG_IDX_GAP       16'h10D2
`define SBG_IDX_REQ       16'h10D3
`define SBG_IDX_ENLO      16'h10D4
`define SBG_IDX_ENHI      16'h10D5
`define SBG_IDX_RETIME    16'h10D6
`define SBG_IDX_DRVA      16'h10D7
`define SBG_IDX_DRVB      16'h10D8
`define SBG_IDX_DRVC      16'h10D9
`define SBG_IDX_SECPATH   16'h10DA
`define SBG_IDX_SYNC      16'h10DB
`define SBG_IDX_MUTE      16'h10DC
// Own status register: live burst-busy state per output
`define SBG_IDX_STATUS    16'h10DD

// Reset values
`define SBG_RST_ZERO      8'h00
`define SBG_RST_DRV       8'h01

// Field positions
`define SBG_REQ_MODE_BIT  6
`define SBG_REQ_CNT_HI    5
`define SBG_REQ_CNT_LO    0
`define SBG_REQ_MASK      8'h7F
`define SBG_ENHI_MASK     8'h0F
`define SBG_RETIME_MASK   8'h01
`define SBG_DRV_MASK      8'h3F
`define SBG_SYNC_MASK     8'h07

// Output count and widths
`define SBG_NOUT          6
`define SBG_CNT_W         6
`define SBG_GAP_W         8

// PRBS7 seed (any nonzero value)
`define SBG_PRBS_SEED     7'h7F

`endif

// ---- src/sbg_output_lane.v ----
// One divider output lane: burst (pulse count) engine, gap timer and PRBS7 source
`include "sbg_defines.vh"

module sbg_output_lane (
    input  wire                  clk_i,         // System clock
    input  wire                  rst_i,         // Async reset, active high
    input  wire                  tick_i,        // One divider output cycle
    input  wire                  burst_en_i,    // Burst mode for this output
    input  wire                  prbs_en_i,     // PRBS mode for this output
    input  wire                  periodic_i,    // Level-triggered repeat mode
    input  wire                  trig_i,        // Trigger level
    input  wire                  trig_rise_i,   // Trigger rising edge
    input  wire [`SBG_CNT_W-1:0] count_i,       // Pulses per burst
    input  wire [`SBG_GAP_W-1:0] gap_i,         // Idle cycles between bursts
    output reg                   out_o,         // Lane output (clock gate / data)
    output wire                  busy_o         // Burst or gap in progress
);

    // One-hot engine states
    localparam ST_IDLE  = 3'b001;
    localparam ST_BURST = 3'b010;
    localparam ST_GAP   = 3'b100;

    reg [2:0]            state_r;     // Engine state
    reg [2:0]            state_nxt;   // Next engine state
    reg [`SBG_CNT_W-1:0] pulse_r;     // Pulses remaining in burst
    reg [`SBG_CNT_W-1:0] pulse_nxt;   // Next pulses remaining
    reg [`SBG_GAP_W-1:0] gap_r;       // Gap cycles remaining
    reg [`SBG_GAP_W-1:0] gap_nxt;     // Next gap remaining
    reg [6:0]            lfsr_r;      // PRBS7 shift register
    reg                  out_nxt;     // Next output value

    assign busy_o = ~state_r[0];

    // Burst/gap sequencing, advanced once per divider cycle
    always @* begin
        state_nxt = state_r;
        pulse_nxt = pulse_r;
        gap_nxt   = gap_r;
        case (state_r)
            ST_IDLE: begin
                // Single mode waits for an edge; periodic mode for a high level
                if (burst_en_i && count_i != {`SBG_CNT_W{1'b0}} &&
                    (periodic_i ? trig_i : trig_rise_i)) begin // R2 R3
                    state_nxt = ST_BURST;
                    pulse_nxt = count_i; // R4
                end
            end
            ST_BURST: begin
                if (tick_i) begin
                    pulse_nxt = pulse_r - 1'b1;
                    if (pulse_r == {{(`SBG_CNT_W-1){1'b0}}, 1'b1}) begin
                        // Gap only matters when bursts repeat
                        if (periodic_i && gap_i != {`SBG_GAP_W{1'b0}}) begin // R8 R1
                            state_nxt = ST_GAP;
                            gap_nxt   = gap_i;
                        end else begin
                            state_nxt = ST_IDLE;
                        end
                    end
                end
            end
            ST_GAP: begin
                if (tick_i) begin
                    gap_nxt = gap_r - 1'b1;
                    if (gap_r == {{(`SBG_GAP_W-1){1'b0}}, 1'b1}) begin
                        state_nxt = ST_IDLE; // R8
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        // Clearing the enable aborts any burst in flight
        if (!burst_en_i) begin
            state_nxt = ST_IDLE;
        end
    end

    // Output select: PRBS first, then muted burst, else normal clock
    // Gate follows the next state so it opens on exactly the counted ticks
    always @* begin
        if (prbs_en_i) begin
            out_nxt = lfsr_r[6]; // R5
        end else if (burst_en_i) begin
            out_nxt = state_nxt[1]; // R6
        end else begin
            out_nxt = 1'b1; // R6
        end
    end

    // State registers
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_r <= ST_IDLE;
            pulse_r <= {`SBG_CNT_W{1'b0}};
            gap_r   <= {`SBG_GAP_W{1'b0}};
            lfsr_r  <= `SBG_PRBS_SEED;
            out_o   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pulse_r <= pulse_nxt;
            gap_r   <= gap_nxt;
            out_o   <= out_nxt;
            // PRBS7 steps at the divider output rate
            if (tick_i) begin
                lfsr_r <= {lfsr_r[5:0], lfsr_r[6] ^ lfsr_r[5]}; // R5
            end
        end
    end

endmodule

// ---- test/sbg_asserts.sv ----
// Port-level assertions for the burst generator top
`include "sbg_defines.vh"
module sbg_asserts (
    input logic        MCLK_I,
    input logic        RESET_I,
    input logic        PSEL_I,
    input logic        PENABLE_I,
    input logic        PWRITE_I,
    input logic [17:0] PADDR_I,
    input logic        PREADY_O,
    input logic [31:0] PRDATA_O,
    input logic        PSLVERR_O,
    input logic        TRIGGER_I,
    input logic [5:0]  DIVIDER_OUT_O,
    input logic [5:0]  BURST_BUSY_O,
    input logic [7:0]  DRIVER_A_O,
    input logic [7:0]  MUTE_MASK_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);
    // Access phase and decoded window, status word included
    wire acc = PSEL_I && PENABLE_I;
    wire hit = PADDR_I[17:2] >= `SBG_IDX_GAP && PADDR_I[17:2] <= `SBG_IDX_STATUS;
    property p_ready; acc |-> PREADY_O; endproperty
    a_ready: assert property (p_ready) else $error("pready low in access");
    property p_slverr; PSLVERR_O == (acc && !hit); endproperty
    a_slverr: assert property (p_slverr) else $error("pslverr wrong");
    property p_rdhi; PRDATA_O[31:8] == 24'h00_0000; endproperty
    a_rdhi: assert property (p_rdhi) else $error("read data high bits set");
    // Read data only reloads in a setup cycle
    property p_rdhold; !PSEL_I |=> $stable(PRDATA_O); endproperty
    a_rdhold: assert property (p_rdhold) else $error("read data moved while idle");
    property p_drva; !$stable(DRIVER_A_O) |-> $past(acc && PWRITE_I && PADDR_I[17:2] == `SBG_IDX_DRVA); endproperty
    a_drva: assert property (p_drva) else $error("driver a changed without write");
    property p_mute; !$stable(MUTE_MASK_O) |-> $past(acc && PWRITE_I && PADDR_I[17:2] == `SBG_IDX_MUTE); endproperty
    a_mute: assert property (p_mute) else $error("mute mask changed without write");
    property p_trig; $rose(BURST_BUSY_O[0]) |-> $past(TRIGGER_I); endproperty
    a_trig: assert property (p_trig) else $error("burst without trigger");
    property p_open; $rose(BURST_BUSY_O[0]) |-> DIVIDER_OUT_O[0]; endproperty
    a_open: assert property (p_open) else $error("burst did not unmute");
endmodule

// ---- test/sbg_div_model.sv ----
// Divider tick source and pulse counter standing at the output side
module sbg_div_model (
    input  logic       clk_i,
    input  logic       rst_i,
    input  logic       clr_i,
    input  logic [5:0] out_i,
    output logic [5:0] tick_o,
    output int         ticks_o,
    output int         ones_o [6]
);
    timeunit 1ns;
    timeprecision 1ps;
    int ph; // Clock phase within one divider cycle
    // Ratio of eight, the least that burst mode allows
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph <= 0;
            tick_o <= 6'h00;
        end else begin
            ph <= (ph + 1) % 8;
            tick_o <= (ph == 7) ? 6'h3F : 6'h00;
        end
    end
    // Ones seen per lane at each divider cycle
    always @(posedge clk_i) begin
        if (clr_i) begin
            ticks_o <= 0;
            foreach (ones_o[i]) ones_o[i] <= 0;
        end else if (tick_o[0]) begin
            ticks_o <= ticks_o + 1;
            foreach (ones_o[i]) ones_o[i] <= ones_o[i] + out_i[i];
        end
    end
endmodule

// ---- test/sysref_pulse_burst_generator_tb.sv ----
// Self-checking bench: registers over APB, PRBS, single and periodic bursts
`include "sbg_defines.vh"
module sysref_pulse_burst_generator_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, trig = 0, clr = 1;
    logic [17:0] paddr = 18'h0_0000;
    logic [31:0] pwdata = 32'h0000_0000, r;
    logic        err_seen = 0;
    wire         pready, pslverr, ret;
    wire  [31:0] prdata;
    wire  [5:0]  tick, dout, busy;
    wire  [7:0]  da, db, dc, sp, sy, mm;
    int          ones [6];
    int          ticks, n, g, k, d;
    int          n_fail = 0, samples_checked = 0, seed = 16936, bursts = 0, bticks = 0;
    always #2 clk = ~clk;
    sbg_top sbg_top_i (.MCLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
        .PRDATA_O(prdata), .PSLVERR_O(pslverr), .TRIGGER_I(trig), .DIV_TICK_I(tick),
        .DIVIDER_OUT_O(dout), .BURST_BUSY_O(busy), .RETIME_EN_O(ret), .DRIVER_A_O(da),
        .DRIVER_B_O(db), .DRIVER_C_O(dc), .SEC_PATH_O(sp), .SYNC_CTRL_O(sy),
        .MUTE_MASK_O(mm));
    sbg_div_model sbg_div_model_i (.clk_i(clk), .rst_i(rst), .clr_i(clr), .out_i(dout),
        .tick_o(tick), .ticks_o(ticks), .ones_o(ones));
    // Lane 0 burst starts and divider cycles spent busy
    always @(posedge clk) begin
        if (clr) begin
            bursts <= 0;
            bticks <= 0;
        end else begin
            bursts <= bursts + $rose(busy[0]);
            bticks <= bticks + (busy[0] && tick[0]);
        end
    end
    task print_verdict;
        if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // A wait that hit its bound ends the run
    task limit(input int cnt, input int lim);
        if (cnt >= lim) begin
            n_fail++;
            $display("[ERR] %0t wait timed out", $time);
            print_verdict;
        end
    endtask
    // One APB transfer; the request holds until pready is seen
    task apb(input logic w, input logic [15:0] idx, input logic [7:0] dat);
        int c;
        @(posedge clk);
        psel <= 1;
        pwr <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, dat};
        @(posedge clk);
        pen <= 1;
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (pready !== 1'b1 && c < 50);
        r = prdata;
        err_seen = pslverr;
        limit(c, 50);
        psel <= 0;
        pen <= 0;
    endtask
    task rd(input logic [15:0] idx, input logic [7:0] exp);
        apb(0, idx, 8'h00);
        chk(r, {24'h00_0000, exp});
    endtask
    task clear;
        @(posedge clk);
        clr <= 1;
        @(posedge clk);
        clr <= 0;
    endtask
    // Writable bits per register; reserved bits read back zero
    function automatic logic [7:0] wmask(input int idx);
        case (idx)
            'h10D3: return 8'h7F;
            'h10D5: return 8'h0F;
            'h10D6: return 8'h01;
            'h10D7, 'h10D8, 'h10D9: return 8'h3F;
            'h10DA: return 8'h0F;
            'h10DB: return 8'h07;
            default: return 8'hFF;
        endcase
    endfunction
    // Configuration output that mirrors a register
    function automatic logic [7:0] outv(input int idx);
        case (idx)
            'h10D6: return {7'h00, ret};
            'h10D7: return da;
            'h10D8: return db;
            'h10D9: return dc;
            'h10DA: return sp;
            'h10DB: return sy;
            default: return mm;
        endcase
    endfunction
    initial begin
        repeat (6) @(posedge clk);
        rst <= 0;
        for (int i = 'h10D2; i <= 'h10DC; i++) rd(16'(i), (i >= 'h10D7 && i <= 'h10D9) ? 1 : 0);
        for (int i = 'h10D2; i <= 'h10DC; i++) begin
            d = $random(seed);
            apb(1, 16'(i), 8'(d));
            rd(16'(i), 8'(d) & wmask(i));
            if (i >= 'h10D6) chk(outv(i), 8'(d) & wmask(i));
        end
        chk(mm, 8'(d));
        apb(1, 16'h10E0, 8'hFF);
        rd(16'h10E0, 8'h00);
        chk(err_seen, 1);
        apb(1, `SBG_IDX_STATUS, 8'h3F);
        rd(`SBG_IDX_STATUS, 8'h00);
        chk(err_seen, 0);
        // PRBS on a_pos, b_pos, b_neg: one full period holds 64 ones
        apb(1, `SBG_IDX_ENLO, 8'hA2);
        apb(1, `SBG_IDX_ENHI, 8'h00);
        clear;
        for (k = 0; ticks < 127 && k < 2000; k++) @(posedge clk);
        limit(k, 2000);
        foreach (ones[i]) chk(ones[i], (i == 0 || i == 2 || i == 3) ? 64 : ticks);
        // Burst enabled lane idles muted, the rest run normally
        apb(1, `SBG_IDX_ENLO, 8'h01);
        repeat (3) @(posedge clk);
        chk(dout, 6'h3E);
        n = 1 + ($random(seed) & 15);
        g = 1 + ($random(seed) & 7);
        apb(1, `SBG_IDX_GAP, 8'(g));
        apb(1, `SBG_IDX_REQ, 8'(n));
        // Single mode: a long high trigger still gives one burst
        repeat (2) begin
            clear;
            trig <= 1;
            repeat ((2 * n + 4) * 8) @(posedge clk);
            trig <= 0;
            repeat (24) @(posedge clk);
            chk(bursts, 1);
            chk(ones[0], n);
        end
        // Periodic mode: bursts repeat with the gap between them
        apb(1, `SBG_IDX_REQ, 8'h40 | 8'(n));
        clear;
        trig <= 1;
        for (k = 0; bursts < 3 && k < 5000; k++) @(posedge clk);
        limit(k, 5000);
        trig <= 0;
        for (k = 0; (busy[0] !== 1'b0 || k < 2) && k < 5000; k++) @(posedge clk);
        limit(k, 5000);
        chk(bursts, 3);
        chk(ones[0], 3 * n);
        chk(bticks, 3 * (n + g));
        print_verdict;
    end
endmodule
bind sbg_top sbg_asserts sbg_asserts_i (.MCLK_I(MCLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PREADY_O(PREADY_O),
    .PRDATA_O(PRDATA_O), .PSLVERR_O(PSLVERR_O), .TRIGGER_I(TRIGGER_I),
    .DIVIDER_OUT_O(DIVIDER_OUT_O), .BURST_BUSY_O(BURST_BUSY_O), .DRIVER_A_O(DRIVER_A_O),
    .MUTE_MASK_O(MUTE_MASK_O));
